// ==== design/pct_timer.sv ====
// Purpose: One channel of a prescaled 24-bit compare timer with APB registers.
// Assumes: Timer input clock is mclk itself; paddr carries the channel offset only.
// Notes: Match interrupt is a level, one cycle behind the flag it mirrors.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RULE1] Active status bit mirrors counter running
// [RULE2] Snapshot follows counter while snapshot enabled
// [RULE3] Prescaler divides timer clock by value+1
// [RULE4] Enabled match with irq enable requests interrupt; the code also needs the mask bit irqMask_q set
// [RULE5] Timeout equals clock times prescale+1 times compare
// [RULE6] Software never programs compare as zero/one
// [RULE7] Compare write restarts count from zero
// [RULE8] Hardware sets match flag on compare match
// [RULE9] Writing one clears flag, zero ignored
// [RULE10] Data register returns snapshot in low bits
// [RULE11] Compare held as 24 bits, match target
// [RULE12] Run enable starts, suspends, resumes counting
// [RULE13] Mode selects one-shot, periodic or continuous
// [RULE14] Counter clear resets prescaler, counter, run
// [RULE15] Interrupt output needs irq enable bit
// [RULE16] Reserved bits read zero, writes ignored
module pct_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic timerIrq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_q;
  logic rstSyncN;

  // Two stages so release never lands mid-edge on the register file
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_q <= 2'b00;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end

  assign rstSyncN = rstPipe_q[1];

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  logic [7:0] regAddr;
  logic [31:0] regWriteData;
  logic regWrite;
  logic [31:0] regReadData;
  logic regHit;

  pct_apb_slave u_apb (
    .mclk(mclk),
    .rstSyncN(rstSyncN),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .regReadData(regReadData),
    .regHit(regHit),
    .regAddr(regAddr),
    .regWriteData(regWriteData),
    .regWrite(regWrite)
  );

  // Write strobes per register
  logic wrControl;
  logic wrCompare;
  logic wrFlag;
  logic wrIrqEnable;
  logic wrIrqClear;

  assign wrControl = regWrite && (regAddr == pct_pkg::OFS_CONTROL);
  assign wrCompare = regWrite && (regAddr == pct_pkg::OFS_COMPARE);
  assign wrFlag = regWrite && (regAddr == pct_pkg::OFS_MATCH_FLAG);
  assign wrIrqEnable = regWrite && (regAddr == pct_pkg::OFS_IRQ_ENABLE);
  assign wrIrqClear = regWrite && (regAddr == pct_pkg::OFS_IRQ_CLEAR);

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  logic counterRunEnable_q;
  logic irqEnable_q;
  logic [1:0] operatingModeSelect_q;
  logic snapshotUpdateEnable_q;
  logic [7:0] prescaleValue_q;
  logic counterClear;
  logic matchEvent;
  logic oneShotStop;

  // Counter clear is a write-one action, never stored
  assign counterClear = wrControl && regWriteData[pct_pkg::CTL_CLEAR_BIT]; // [RULE14]

  // One-shot drops the run bit on its own match
  assign oneShotStop = matchEvent &&
    (operatingModeSelect_q == pct_pkg::MODE_ONE_SHOT); // [RULE13]

  // Run enable: hardware stop and clear outrank a software write
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      counterRunEnable_q <= pct_pkg::CTL_RESET[pct_pkg::CTL_RUN_BIT];
    end else if (counterClear || oneShotStop) begin
      counterRunEnable_q <= 1'b0; // [RULE14]
    end else if (wrControl) begin
      counterRunEnable_q <= regWriteData[pct_pkg::CTL_RUN_BIT]; // [RULE12]
    end
  end

  // Remaining control fields; reserved bits have no storage
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irqEnable_q <= pct_pkg::CTL_RESET[pct_pkg::CTL_IRQEN_BIT];
      operatingModeSelect_q <= pct_pkg::CTL_RESET[pct_pkg::CTL_MODE_HI:pct_pkg::CTL_MODE_LO];
      snapshotUpdateEnable_q <= pct_pkg::CTL_RESET[pct_pkg::CTL_SNAPEN_BIT];
      prescaleValue_q <= pct_pkg::CTL_RESET[pct_pkg::CTL_PRESCALE_HI:pct_pkg::CTL_PRESCALE_LO];
    end else if (wrControl) begin
      irqEnable_q <= regWriteData[pct_pkg::CTL_IRQEN_BIT];
      operatingModeSelect_q <= regWriteData[pct_pkg::CTL_MODE_HI:pct_pkg::CTL_MODE_LO];
      snapshotUpdateEnable_q <= regWriteData[pct_pkg::CTL_SNAPEN_BIT];
      prescaleValue_q <= regWriteData[pct_pkg::CTL_PRESCALE_HI:pct_pkg::CTL_PRESCALE_LO];
    end
  end

  // ----------------------------------------------------------------
  // Compare value
  // ----------------------------------------------------------------
  logic [23:0] compareValue_q;

  // Only the low 24 bits are kept; upper write bits are dropped
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      compareValue_q <= pct_pkg::COMPARE_RESET[pct_pkg::COUNT_WIDTH-1:0];
    end else if (wrCompare) begin
      compareValue_q <= regWriteData[pct_pkg::COUNT_WIDTH-1:0]; // [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [7:0] prescaleCount_q;
  logic countTick;

  // Tick once every prescale+1 clocks; a value of zero ticks every clock
  assign countTick = counterRunEnable_q && (prescaleCount_q == prescaleValue_q); // [RULE3]

  // Restarting here on a compare write keeps the first period full length
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      prescaleCount_q <= pct_pkg::PRESCALE_ZERO;
    end else if (counterClear || wrCompare) begin
      prescaleCount_q <= pct_pkg::PRESCALE_ZERO; // [RULE14] [RULE7]
    end else if (countTick) begin
      prescaleCount_q <= pct_pkg::PRESCALE_ZERO; // [RULE3]
    end else if (counterRunEnable_q) begin
      prescaleCount_q <= prescaleCount_q + pct_pkg::PRESCALE_ONE; // [RULE3]
    end
  end

  // ----------------------------------------------------------------
  // Up-counter and match
  // ----------------------------------------------------------------
  logic [23:0] upCount_q;
  logic [23:0] upCountNext;
  logic continuousMode;

  assign upCountNext = upCount_q + pct_pkg::COUNT_ONE;
  assign continuousMode = (operatingModeSelect_q == pct_pkg::MODE_CONTINUOUS);

  // Match when the counter steps onto the compare value. Compare values of
  // zero or one are left to software to avoid; hardware takes no guard.
  assign matchEvent = countTick && (upCountNext == compareValue_q); // [RULE4] [RULE5] [RULE11] [RULE6]

  // Counter holds while stopped, so a re-enable resumes where it left off
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      upCount_q <= pct_pkg::COUNT_ZERO;
    end else if (counterClear || wrCompare) begin
      upCount_q <= pct_pkg::COUNT_ZERO; // [RULE14] [RULE7]
    end else if (matchEvent && !continuousMode) begin
      upCount_q <= pct_pkg::COUNT_ZERO; // [RULE5] [RULE13]
    end else if (countTick) begin
      upCount_q <= upCountNext; // [RULE12] [RULE13]
    end
  end

  // ----------------------------------------------------------------
  // Snapshot register
  // ----------------------------------------------------------------
  logic [23:0] countSnapshot_q;

  // Follows the counter each cycle; freezes the last value when disabled
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      countSnapshot_q <= pct_pkg::COUNT_ZERO;
    end else if (snapshotUpdateEnable_q) begin
      countSnapshot_q <= upCount_q; // [RULE2]
    end
  end

  // ----------------------------------------------------------------
  // Match flag and interrupt
  // ----------------------------------------------------------------
  logic matchIrqFlag_q;
  logic irqMask_q;
  logic flagClear;
  logic timerIrq_q;

  // Either clear path takes a one in bit zero
  assign flagClear = (wrFlag || wrIrqClear) && regWriteData[pct_pkg::FLAG_BIT]; // [RULE9]

  // A match in the clearing cycle wins, so no event is lost
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      matchIrqFlag_q <= 1'b0;
    end else if (matchEvent) begin
      matchIrqFlag_q <= 1'b1; // [RULE8]
    end else if (flagClear) begin
      matchIrqFlag_q <= 1'b0; // [RULE9]
    end
  end

  // Extra mask lets software gate the line without touching control
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irqMask_q <= pct_pkg::IRQ_ENABLE_RESET[pct_pkg::FLAG_BIT];
    end else if (wrIrqEnable) begin
      irqMask_q <= regWriteData[pct_pkg::FLAG_BIT];
    end
  end

  // Level output, registered so the pin never glitches
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      timerIrq_q <= 1'b0;
    end else begin
      timerIrq_q <= matchIrqFlag_q && irqEnable_q && irqMask_q; // [RULE4] [RULE15]
    end
  end

  assign timerIrq = timerIrq_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] controlWord;

  // Clear bit reads zero; active status is the live run state
  always_comb begin
    controlWord = pct_pkg::ZERO_WORD; // [RULE16]
    controlWord[pct_pkg::CTL_RUN_BIT] = counterRunEnable_q;
    controlWord[pct_pkg::CTL_IRQEN_BIT] = irqEnable_q;
    controlWord[pct_pkg::CTL_MODE_HI:pct_pkg::CTL_MODE_LO] = operatingModeSelect_q;
    controlWord[pct_pkg::CTL_ACTIVE_BIT] = counterRunEnable_q; // [RULE1]
    controlWord[pct_pkg::CTL_SNAPEN_BIT] = snapshotUpdateEnable_q;
    controlWord[pct_pkg::CTL_PRESCALE_HI:pct_pkg::CTL_PRESCALE_LO] = prescaleValue_q;
  end

  // Unmapped offsets report no hit and get an error answer
  always_comb begin
    regReadData = pct_pkg::ZERO_WORD;
    regHit = 1'b1;
    unique case (regAddr)
      pct_pkg::OFS_CONTROL: begin
        regReadData = controlWord;
      end
      pct_pkg::OFS_COMPARE: begin
        regReadData = pct_pkg::word24(compareValue_q); // [RULE16]
      end
      pct_pkg::OFS_MATCH_FLAG, pct_pkg::OFS_IRQ_STATUS: begin
        regReadData = pct_pkg::ZERO_WORD;
        regReadData[pct_pkg::FLAG_BIT] = matchIrqFlag_q; // [RULE16]
      end
      pct_pkg::OFS_SNAPSHOT: begin
        regReadData = pct_pkg::word24(countSnapshot_q); // [RULE10]
      end
      pct_pkg::OFS_IRQ_ENABLE: begin
        regReadData = pct_pkg::ZERO_WORD;
        regReadData[pct_pkg::FLAG_BIT] = irqMask_q;
      end
      pct_pkg::OFS_IRQ_CLEAR: begin
        regReadData = pct_pkg::ZERO_WORD;
      end
      default: begin
        regHit = 1'b0;
      end
    endcase
  end

endmodule : pct_timer
`default_nettype wire

// ==== design/pct_pkg.sv ====
// Purpose: Shared constants and types of the prescaled compare timer.
// Assumes: 32-bit APB data, one register per aligned word.
// Notes: Every offset, field position, reset value and code lives here.
package pct_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COMPARE = 8'h04;
  localparam logic [7:0] OFS_MATCH_FLAG = 8'h08;
  localparam logic [7:0] OFS_SNAPSHOT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_RUN_BIT = 30;
  localparam int CTL_IRQEN_BIT = 29;
  localparam int CTL_MODE_HI = 28;
  localparam int CTL_MODE_LO = 27;
  localparam int CTL_CLEAR_BIT = 26;
  localparam int CTL_ACTIVE_BIT = 25;
  localparam int CTL_SNAPEN_BIT = 16;
  localparam int CTL_PRESCALE_HI = 7;
  localparam int CTL_PRESCALE_LO = 0;
  localparam int FLAG_BIT = 0;
  localparam int COUNT_WIDTH = 24;
  localparam int PRESCALE_WIDTH = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL_RESET = 32'h0000_0005;
  localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [23:0] COUNT_ZERO = 24'h00_0000;
  localparam logic [23:0] COUNT_ONE = 24'h00_0001;
  localparam logic [7:0] PRESCALE_ZERO = 8'h00;
  localparam logic [7:0] PRESCALE_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ONE_SHOT = 2'h0,
    MODE_PERIODIC = 2'h1,
    MODE_RESERVED = 2'h2,
    MODE_CONTINUOUS = 2'h3
  } pct_mode_type;

  // Bus handshake states, Gray along idle to acknowledge
  typedef enum logic [1:0] {
    APB_IDLE = 2'h0,
    APB_ACK = 2'h1
  } pct_apb_state_type;

  // Place a 24-bit quantity in the low bits of a bus word
  function automatic logic [31:0] word24(input logic [23:0] value);
    word24 = {8'h00, value};
  endfunction : word24

endpackage : pct_pkg

// ==== design/pct_apb_slave.sv ====
// Purpose: APB slave front end of the compare timer.
// Assumes: One wait state per transfer; reads have no side effects.
// Notes: Strobes fire at the edge where the master samples pready high.
`timescale 1ns/1ps
`default_nettype none
module pct_apb_slave (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstSyncN,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register side
  input wire logic [31:0] regReadData,
  input wire logic regHit,
  output logic [7:0] regAddr,
  output logic [31:0] regWriteData,
  output logic regWrite
);

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  pct_pkg::pct_apb_state_type state_q;
  logic accessStart;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Access phase seen for the first time in idle
  assign accessStart = psel && penable && (state_q == pct_pkg::APB_IDLE);

  // Address and data pass straight through, held stable by the master
  assign regAddr = paddr;
  assign regWriteData = pwdata;
  // Write lands only on the completing edge
  assign regWrite = psel && penable && pwrite && pready_q && regHit;

  // One wait cycle, then acknowledge for exactly one cycle
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_q <= pct_pkg::APB_IDLE;
    end else begin
      unique case (state_q)
        pct_pkg::APB_IDLE: begin
          if (accessStart) begin
            state_q <= pct_pkg::APB_ACK;
          end
        end
        pct_pkg::APB_ACK: begin
          state_q <= pct_pkg::APB_IDLE;
        end
        default: begin
          state_q <= pct_pkg::APB_IDLE;
        end
      endcase
    end
  end

  // Response flops; read data is captured so it stands with pready
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= pct_pkg::ZERO_WORD;
    end else begin
      pready_q <= accessStart;
      pslverr_q <= accessStart && !regHit;
      if (accessStart && !pwrite && regHit) begin
        prdata_q <= regReadData;
      end else begin
        prdata_q <= pct_pkg::ZERO_WORD;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : pct_apb_slave
`default_nettype wire

// ==== tb/pct_timer_sva.sv ====
// Purpose: Port-level checker for the compare timer.
// Assumes: Only the top module's ports are visible.
// Notes: A shadow of the irq enable bit is rebuilt from completed writes.
`timescale 1ns/1ps
`default_nettype none
module pct_timer_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt
  input wire logic timerIrq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic rdDone;
  logic wrDone;
  logic irqEnQ;
  // Transfers as seen at the edge that samples pready
  assign rdDone = psel && penable && pready && !pwrite;
  assign wrDone = psel && penable && pready && pwrite;
  // Shadow of irq enable, since the design's copy is hidden
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqEnQ <= 1'b0;
    end else if (wrDone && paddr == pct_pkg::OFS_CONTROL) begin
      irqEnQ <= pwdata[pct_pkg::CTL_IRQEN_BIT];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ctl_resv;
    rdDone && paddr == pct_pkg::OFS_CONTROL |->
      !prdata[31] && !prdata[26] && prdata[24:17] == 8'h00 && prdata[15:8] == 8'h00;
  endproperty
  a_ctl_resv: assert property (p_ctl_resv) else $error("control reserved bits set");
  property p_active;
    rdDone && paddr == pct_pkg::OFS_CONTROL |-> prdata[25] == prdata[30];
  endproperty
  a_active: assert property (p_active) else $error("active differs from run");
  property p_cmp_width;
    rdDone && paddr == pct_pkg::OFS_COMPARE |-> prdata[31:24] == 8'h00;
  endproperty
  a_cmp_width: assert property (p_cmp_width) else $error("compare wider than 24");
  property p_snap_width;
    rdDone && paddr == pct_pkg::OFS_SNAPSHOT |-> prdata[31:24] == 8'h00;
  endproperty
  a_snap_width: assert property (p_snap_width) else $error("snapshot wider than 24");
  property p_irq_gate;
    !irqEnQ && !$past(irqEnQ) |-> !timerIrq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_flag_keep;
    wrDone && paddr == pct_pkg::OFS_MATCH_FLAG && !pwdata[0] && timerIrq |=> timerIrq;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("zero write cleared flag");
  property p_unmapped;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad error response");
  property p_irq_flag;
    rdDone && paddr == pct_pkg::OFS_MATCH_FLAG && timerIrq && $past(timerIrq) |-> prdata[0];
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("irq high, flag reads 0");
endmodule : pct_timer_sva
bind pct_timer pct_timer_sva u_pct_timer_sva (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timerIrq(timerIrq));
`default_nettype wire

// ==== tb/pct_timer_tb.sv ====
// Purpose: Self-checking bench for the compare timer.
// Assumes: Timer clock is mclk; APB answers within a few cycles.
// Notes: Small compare values keep every period short.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin badCount++; \
  $display("wrong value at %0t: got %0h want %0h", $time, (a), (e)); end end
module pct_timer_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timerIrq;
  logic [31:0] rd;
  logic err;
  logic [31:0] snap;
  logic irqPrev = 1'b0;
  int cyc = 0;
  int rise[$];
  int badCount = 0;
  int checked = 0;
  always #5 mclk = ~mclk;
  // Cycle stamps of interrupt rising edges, for period checks
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    irqPrev <= timerIrq;
    if (timerIrq === 1'b1 && irqPrev === 1'b0) rise.push_back(cyc);
  end
  pct_timer u_pct_timer (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerIrq(timerIrq));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic endOfTest();
    $display("comparisons %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : endOfTest
  task automatic hang();
    badCount++;
    $display("wrong value at %0t: no answer", $time);
    endOfTest();
  endtask : hang
  // One transfer, then an idle cycle so psel never gets two drives at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (n > 50) hang();
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e);
  endtask : rdChk
  task automatic waitIrq(input logic v);
    int n;
    n = 0;
    while (timerIrq !== v) begin
      @(posedge mclk);
      n++;
      if (n > 300) hang();
    end
  endtask : waitIrq
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tRegs();
    rdChk(pct_pkg::OFS_CONTROL, pct_pkg::CTL_RESET);
    rdChk(pct_pkg::OFS_COMPARE, 32'h0000_0000);
    rdChk(pct_pkg::OFS_MATCH_FLAG, 32'h0000_0000);
    rdChk(pct_pkg::OFS_SNAPSHOT, 32'h0000_0000);
    rdChk(pct_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    rdChk(8'h1C, 32'h0000_0000);
    `CHK(err, 1'b1);
    apb(1'b1, pct_pkg::OFS_COMPARE, 32'hFFFF_FFFF);
    rdChk(pct_pkg::OFS_COMPARE, 32'h00FF_FFFF);
    // Clear wins over run in the same write
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'hFFFF_FFFF);
    rdChk(pct_pkg::OFS_CONTROL, 32'h3801_00FF);
    apb(1'b1, pct_pkg::OFS_SNAPSHOT, 32'hFFFF_FFFF);
    rdChk(pct_pkg::OFS_SNAPSHOT, 32'h0000_0000);
  endtask : tRegs
  task automatic tPeriodic();
    rise.delete();
    apb(1'b1, pct_pkg::OFS_COMPARE, 32'h0000_0006);
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'h6800_0002);
    repeat (3) begin
      waitIrq(1'b1);
      apb(1'b1, pct_pkg::OFS_MATCH_FLAG, 32'h0000_0001);
      waitIrq(1'b0);
    end
    `CHK(rise.size(), 3);
    `CHK(rise[1] - rise[0], 18);
    `CHK(rise[2] - rise[1], 18);
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'h0400_0000);
  endtask : tPeriodic
  task automatic tOneShot();
    apb(1'b1, pct_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
    apb(1'b1, pct_pkg::OFS_COMPARE, 32'h0000_0004);
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'h6000_0000);
    repeat (20) @(posedge mclk);
    `CHK(timerIrq, 1'b0);
    rdChk(pct_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    rdChk(pct_pkg::OFS_CONTROL, 32'h2000_0000);
    apb(1'b1, pct_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    waitIrq(1'b1);
    apb(1'b1, pct_pkg::OFS_MATCH_FLAG, 32'h0000_0000);
    rdChk(pct_pkg::OFS_MATCH_FLAG, 32'h0000_0001);
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    `CHK(timerIrq, 1'b0);
    apb(1'b1, pct_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
    rdChk(pct_pkg::OFS_MATCH_FLAG, 32'h0000_0000);
  endtask : tOneShot
  task automatic tContinuous();
    apb(1'b1, pct_pkg::OFS_COMPARE, 32'h0000_0004);
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'h5801_0000);
    repeat (30) @(posedge mclk);
    rdChk(pct_pkg::OFS_CONTROL, 32'h5A01_0000);
    apb(1'b0, pct_pkg::OFS_SNAPSHOT, 32'h0000_0000);
    `CHK(rd[23:0] > 24'h00_0004, 1'b1);
    rdChk(pct_pkg::OFS_MATCH_FLAG, 32'h0000_0001);
    // A new compare value restarts the count while running
    apb(1'b1, pct_pkg::OFS_COMPARE, 32'h0000_1000);
    apb(1'b0, pct_pkg::OFS_SNAPSHOT, 32'h0000_0000);
    `CHK(rd < 32'h0000_0008, 1'b1);
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'h1801_0000);
    apb(1'b0, pct_pkg::OFS_SNAPSHOT, 32'h0000_0000);
    snap = rd;
    repeat (10) @(posedge mclk);
    rdChk(pct_pkg::OFS_SNAPSHOT, snap);
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'h5801_0000);
    repeat (10) @(posedge mclk);
    apb(1'b0, pct_pkg::OFS_SNAPSHOT, 32'h0000_0000);
    `CHK(rd > snap && rd < snap + 32'h0000_0020, 1'b1);
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'h5800_0000);
    apb(1'b0, pct_pkg::OFS_SNAPSHOT, 32'h0000_0000);
    snap = rd;
    repeat (5) @(posedge mclk);
    rdChk(pct_pkg::OFS_SNAPSHOT, snap);
    apb(1'b1, pct_pkg::OFS_CONTROL, 32'h5C01_0000);
    rdChk(pct_pkg::OFS_CONTROL, 32'h1801_0000);
    rdChk(pct_pkg::OFS_SNAPSHOT, 32'h0000_0000);
  endtask : tContinuous
  // Reset for 20 cycles, let the synchroniser settle, then run
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    tRegs();
    tPeriodic();
    tOneShot();
    tContinuous();
    endOfTest();
  end
endmodule : pct_timer_tb
`default_nettype wire
